//--- pmtr_pkg.sv
// package of constants and types shared by both ends of the program memory table read link
package pmtr_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 13;
    localparam int          WORD_W       = 16;
    localparam int          BYTE_W       = 8;
    localparam int          HIGH_W       = 5;
    localparam int          MEM_DEPTH    = 8192;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam logic [15:0] WORD_ZERO    = 16'h0000;
    localparam logic [4:0]  HIGH_ZERO    = 5'h00;
    // ------------------------------------------------------------
    // instruction kinds requested by the core
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PMTR_OP_NONE   = 3'h0,
        PMTR_OP_TABRD  = 3'h1,
        PMTR_OP_BRANCH = 3'h2,
        PMTR_OP_WRHIGH = 3'h3
    } pmtr_op_t;
    // sector zero is the only one reachable by short forms
    localparam logic [1:0]  SECTOR_ZERO  = 2'h0;
    localparam int          SECTOR_W     = 2;
    // instruction cycles for a table read or a branch
    localparam logic [1:0]  CYCLES_LONG  = 2'h2;
    localparam logic [1:0]  CYCLES_ONE   = 2'h1;
    // device states, one-hot
    typedef enum logic [3:0] {
        PMTR_ST_RESET = 4'b0001,
        PMTR_ST_FETCH = 4'b0010,
        PMTR_ST_TABLE = 4'b0100,
        PMTR_ST_JUMP  = 4'b1000
    } pmtr_state_t;
endpackage

//--- pmtr_if.sv
// interface joining the core end to the program memory end
`timescale 1ns/1ns
`default_nettype none
interface pmtr_if;
    // ------------------------------------------------------------
    // core request and answer
    // ------------------------------------------------------------
    logic                  req_valid;
    pmtr_pkg::pmtr_op_t    req_op;
    logic                  req_long;
    logic [1:0]            req_sector;
    logic [7:0]            req_dest;
    logic [12:0]           req_target;
    logic [7:0]            table_ptr_low;
    logic [4:0]            table_ptr_high;
    logic [7:0]            high_wdata;
    logic                  busy;
    logic                  done;
    logic                  fault;
    logic [12:0]           pc;
    logic [15:0]           instr;
    logic                  instr_valid;
    logic                  dest_we;
    logic [7:0]            dest_addr;
    logic [7:0]            dest_data;
    logic [7:0]            table_high_byte_latch;
    // ------------------------------------------------------------
    // serial pins: device side and tool side enables
    // ------------------------------------------------------------
    logic                  dev_data_out;
    logic                  dev_data_oe;
    logic                  tool_data_out;
    logic                  tool_data_oe;
    logic                  tool_clock;
    logic                  data_level;
    // open-drain style resolve: any driver at low wins, idle is high
    assign data_level = !((dev_data_oe && !dev_data_out) || (tool_data_oe && !tool_data_out));

    modport device (
        input  req_valid, req_op, req_long, req_sector, req_dest, req_target,
        input  table_ptr_low, table_ptr_high, high_wdata,
        output busy, done, fault, pc, instr, instr_valid,
        output dest_we, dest_addr, dest_data, table_high_byte_latch,
        output dev_data_out, dev_data_oe,
        input  tool_data_out, tool_data_oe, tool_clock, data_level
    );
    modport core (
        output req_valid, req_op, req_long, req_sector, req_dest, req_target,
        output table_ptr_low, table_ptr_high, high_wdata,
        input  busy, done, fault, pc, instr, instr_valid,
        input  dest_we, dest_addr, dest_data, table_high_byte_latch,
        output tool_data_out, tool_data_oe, tool_clock,
        input  dev_data_out, dev_data_oe, data_level
    );
endinterface
`default_nettype wire

//--- pmtr_device.sv
// program memory end: program store, table read path and shared serial pins
// Function
// - store of 8K words, 16 bits each
// - fetching restarts at location zero after reset
// - fetch by program counter, tables by pointer
// - table address formed from both pointer registers
// - low table byte written to named register
// - high byte to latch, unused bits zero
// - short forms sector zero, extended forms elsewhere
// - table read instructions take two cycles
// - high byte latch readable and writable
// - software avoids table reads in both contexts
// - serial programming uses one two-way data pin
// - nothing else drives programming pins meanwhile
// - debug data two-way, debug clock tool driven
// - debug use mutes shared pin functions
// - debug pins double as programming pins
// - branches take one extra cycle
`timescale 1ns/1ns
`default_nettype none
module pmtr_device #(
    parameter int ADDR_W = pmtr_pkg::ADDR_W,
    parameter int WORD_W = pmtr_pkg::WORD_W
) (
    input  wire logic          clk_sys,
    input  wire logic          reset_n,
    pmtr_if.device             bus,
    input  wire logic          debug_active,
    input  wire logic          prog_active,
    input  wire logic          load_we,
    input  wire logic [12:0]   load_addr,
    input  wire logic [15:0]   load_data,
    input  wire logic          pin_func_data,
    output logic               prog_serial_data_in,
    output logic               prog_serial_clock,
    output logic               debug_serial_data_in,
    output logic               debug_serial_clock,
    output logic               pin_func_in
);
    // ------------------------------------------------------------
    // program store
    // ------------------------------------------------------------
    logic [WORD_W-1:0]         mem [0:pmtr_pkg::MEM_DEPTH-1];
    pmtr_pkg::pmtr_state_t     state;
    logic [ADDR_W-1:0]         table_addr;
    logic [WORD_W-1:0]         table_word;
    logic [7:0]                dest_hold;
    logic                      sector_ok;
    logic                      serial_mode;

    // joined pointer, high register supplies bits 12..8
    function automatic logic [12:0] join_ptr(input logic [7:0] lo, input logic [4:0] hi);
        join_ptr = {hi, lo};
    endfunction

    // writes come from the loader port only; no flash erase path here
    // a load and a table read of one word in one cycle: the read sees the old word
    always_ff @(posedge clk_sys) begin
        if (load_we) begin
            mem[load_addr] <= load_data;
        end
    end

    // short form must target sector zero, extended form any other sector
    assign sector_ok = bus.req_long ? (bus.req_sector != pmtr_pkg::SECTOR_ZERO)
                                    : (bus.req_sector == pmtr_pkg::SECTOR_ZERO);

    // ------------------------------------------------------------
    // sequencer: one cycle for plain fetch, two for table and branch
    // ------------------------------------------------------------
    // requests are only taken in fetch; the core waits for busy low before the next
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state      <= pmtr_pkg::PMTR_ST_RESET;
            table_addr <= pmtr_pkg::RESET_VECTOR;
            dest_hold  <= pmtr_pkg::BYTE_ZERO;
        end else begin
            case (state)
                pmtr_pkg::PMTR_ST_RESET: begin
                    state <= pmtr_pkg::PMTR_ST_FETCH;
                end
                pmtr_pkg::PMTR_ST_FETCH: begin
                    if (bus.req_valid && bus.req_op == pmtr_pkg::PMTR_OP_TABRD && sector_ok) begin
                        state      <= pmtr_pkg::PMTR_ST_TABLE;
                        table_addr <= join_ptr(bus.table_ptr_low, bus.table_ptr_high);
                        dest_hold  <= bus.req_dest;
                    end else if (bus.req_valid && bus.req_op == pmtr_pkg::PMTR_OP_BRANCH) begin
                        state <= pmtr_pkg::PMTR_ST_JUMP;
                    end
                end
                pmtr_pkg::PMTR_ST_TABLE: begin
                    state <= pmtr_pkg::PMTR_ST_FETCH;
                end
                pmtr_pkg::PMTR_ST_JUMP: begin
                    state <= pmtr_pkg::PMTR_ST_FETCH;
                end
                default: begin
                    state <= pmtr_pkg::PMTR_ST_RESET;
                end
            endcase
        end
    end

    // pointer was registered a cycle earlier, so a plain read of the store
    // still finishes inside the two-cycle table instruction
    assign table_word = mem[table_addr];

    // ------------------------------------------------------------
    // program counter and instruction fetch
    // ------------------------------------------------------------
    // fetch pauses while a request is pending, so pc keeps the next instruction
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus.pc          <= pmtr_pkg::RESET_VECTOR;
            bus.instr       <= pmtr_pkg::WORD_ZERO;
            bus.instr_valid <= 1'b0;
        end else begin
            bus.instr_valid <= 1'b0;
            if (state == pmtr_pkg::PMTR_ST_JUMP) begin
                bus.pc <= bus.req_target; // branch taken in second cycle
            end else if (state == pmtr_pkg::PMTR_ST_FETCH && !(bus.req_valid
                         && bus.req_op != pmtr_pkg::PMTR_OP_NONE)) begin
                bus.instr       <= mem[bus.pc];
                bus.instr_valid <= 1'b1;
                bus.pc          <= bus.pc + 13'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // results: destination byte, high byte latch, status
    // ------------------------------------------------------------
    // both halves land on one edge, so the latch never lags the destination byte
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus.dest_we               <= 1'b0;
            bus.dest_addr             <= pmtr_pkg::BYTE_ZERO;
            bus.dest_data             <= pmtr_pkg::BYTE_ZERO;
            bus.table_high_byte_latch <= pmtr_pkg::BYTE_ZERO;
            bus.done                  <= 1'b0;
            bus.fault                 <= 1'b0;
        end else begin
            bus.dest_we <= 1'b0;
            bus.done    <= 1'b0;
            bus.fault   <= 1'b0;
            if (state == pmtr_pkg::PMTR_ST_TABLE) begin
                // word arrives from the combinational read of the registered pointer at the second cycle
                bus.dest_we               <= 1'b1;
                bus.dest_addr             <= dest_hold;
                bus.dest_data             <= table_word[7:0];
                bus.table_high_byte_latch <= table_word[15:8];
                bus.done                  <= 1'b1;
            end else if (state == pmtr_pkg::PMTR_ST_JUMP) begin
                bus.done <= 1'b1;
            end else if (state == pmtr_pkg::PMTR_ST_FETCH && bus.req_valid) begin
                if (bus.req_op == pmtr_pkg::PMTR_OP_WRHIGH) begin
                    bus.table_high_byte_latch <= bus.high_wdata;
                    bus.done                  <= 1'b1;
                end else if (bus.req_op == pmtr_pkg::PMTR_OP_TABRD && !sector_ok) begin
                    bus.fault <= 1'b1;
                end
            end
        end
    end

    // busy covers the extra cycle of table reads and branches
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus.busy <= 1'b1;
        end else begin
            bus.busy <= (state == pmtr_pkg::PMTR_ST_RESET)
                     || (state == pmtr_pkg::PMTR_ST_FETCH && bus.req_valid
                         && ((bus.req_op == pmtr_pkg::PMTR_OP_TABRD && sector_ok)
                             || bus.req_op == pmtr_pkg::PMTR_OP_BRANCH));
        end
    end

    // ------------------------------------------------------------
    // shared serial pins; the device only listens in serial mode, protocol lives elsewhere
    // ------------------------------------------------------------
    assign serial_mode = prog_active || debug_active;

    // one register stage on every pin sample; the tool clock is slow beside clk_sys
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus.dev_data_out     <= 1'b1;
            bus.dev_data_oe      <= 1'b0;
            prog_serial_data_in  <= 1'b1;
            prog_serial_clock    <= 1'b0;
            debug_serial_data_in <= 1'b1;
            debug_serial_clock   <= 1'b0;
            pin_func_in          <= 1'b0;
        end else begin
            // pin released in serial mode so the tool owns it
            bus.dev_data_out     <= serial_mode ? 1'b1 : pin_func_data;
            bus.dev_data_oe      <= !serial_mode;
            prog_serial_data_in  <= prog_active ? bus.data_level : 1'b1;
            prog_serial_clock    <= prog_active ? bus.tool_clock : 1'b0;
            debug_serial_data_in <= debug_active ? bus.data_level : 1'b1;
            debug_serial_clock   <= debug_active ? bus.tool_clock : 1'b0;
            // muted while the pins serve debug or programming
            pin_func_in          <= serial_mode ? 1'b0 : bus.data_level;
        end
    end
endmodule
`default_nettype wire

//--- pmtr_core.sv
// core end: issues table reads, branches and latch writes, drives the tool pins
`timescale 1ns/1ns
`default_nettype none
module pmtr_core (
    input  wire logic          clk_sys,
    input  wire logic          reset_n,
    pmtr_if.core               bus,
    input  wire logic          user_valid,
    input  wire logic [2:0]    user_op,
    input  wire logic          user_long,
    input  wire logic [1:0]    user_sector,
    input  wire logic [7:0]    user_dest,
    input  wire logic [12:0]   user_target,
    input  wire logic [7:0]    user_ptr_low,
    input  wire logic [4:0]    user_ptr_high,
    input  wire logic [7:0]    user_high_wdata,
    input  wire logic          user_tool_data,
    input  wire logic          user_tool_oe,
    input  wire logic          user_tool_clock,
    output logic               user_ready,
    output logic               user_done,
    output logic [7:0]         user_rdata,
    output logic [7:0]         user_high
);
    // ------------------------------------------------------------
    // request register: one outstanding request, held while busy
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus.req_valid      <= 1'b0;
            bus.req_op         <= pmtr_pkg::PMTR_OP_NONE;
            bus.req_long       <= 1'b0;
            bus.req_sector     <= pmtr_pkg::SECTOR_ZERO;
            bus.req_dest       <= pmtr_pkg::BYTE_ZERO;
            bus.req_target     <= pmtr_pkg::RESET_VECTOR;
            bus.table_ptr_low  <= pmtr_pkg::BYTE_ZERO;
            bus.table_ptr_high <= pmtr_pkg::HIGH_ZERO;
            bus.high_wdata     <= pmtr_pkg::BYTE_ZERO;
        end else if (!bus.busy && !bus.req_valid) begin
            // one request per free slot keeps table reads from overlapping
            bus.req_valid      <= user_valid;
            bus.req_op         <= pmtr_pkg::pmtr_op_t'(user_op);
            bus.req_long       <= user_long;
            bus.req_sector     <= user_sector;
            bus.req_dest       <= user_dest;
            bus.req_target     <= user_target;
            bus.table_ptr_low  <= user_ptr_low;
            bus.table_ptr_high <= user_ptr_high;
            bus.high_wdata     <= user_high_wdata;
        end else begin
            bus.req_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // answers to the user side
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            user_ready <= 1'b0;
            user_done  <= 1'b0;
            user_rdata <= pmtr_pkg::BYTE_ZERO;
            user_high  <= pmtr_pkg::BYTE_ZERO;
        end else begin
            user_ready <= !bus.busy && !bus.req_valid && !user_valid;
            user_done  <= bus.done || bus.fault;
            if (bus.dest_we) begin
                user_rdata <= bus.dest_data;
            end
            user_high <= bus.table_high_byte_latch;
        end
    end

    // tool side pins; only this end drives them while programming
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bus.tool_data_out <= 1'b1;
            bus.tool_data_oe  <= 1'b0;
            bus.tool_clock    <= 1'b0;
        end else begin
            bus.tool_data_out <= user_tool_data;
            bus.tool_data_oe  <= user_tool_oe;
            bus.tool_clock    <= user_tool_clock;
        end
    end
endmodule
`default_nettype wire

//--- pmtr_checker_assertions.sv
// concurrent checks on the link between the core end and the program memory end
`timescale 1ns/1ns
`default_nettype none
module pmtr_checker (
    input wire logic               clk_sys,
    input wire logic               reset_n,
    input wire logic               req_valid,
    input wire logic [2:0]         req_op,
    input wire logic               req_long,
    input wire logic [1:0]         req_sector,
    input wire logic [7:0]         req_dest,
    input wire logic [12:0]        req_target,
    input wire logic [7:0]         high_wdata,
    input wire logic               busy,
    input wire logic               done,
    input wire logic               fault,
    input wire logic [12:0]        pc,
    input wire logic               dest_we,
    input wire logic [7:0]         dest_addr,
    input wire logic [7:0]         table_high_byte_latch
);
    // ------------------------------------------------
    // request decode
    // ------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // extended forms pair with a nonzero sector, short forms with sector zero
    wire logic form_ok = req_long ^ (req_sector == pmtr_pkg::SECTOR_ZERO);
    wire logic rd_req  = req_valid && req_op == pmtr_pkg::PMTR_OP_TABRD;
    wire logic br_req  = req_valid && req_op == pmtr_pkg::PMTR_OP_BRANCH;
    wire logic wr_req  = req_valid && req_op == pmtr_pkg::PMTR_OP_WRHIGH;
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    a_tabrd_two_cycles: assert property (rd_req && form_ok |-> ##1 busy ##1 (dest_we && done))
        else $error("table read late or early");
    a_tabrd_dest_reg: assert property (rd_req && form_ok |-> ##2 dest_addr == $past(req_dest, 2))
        else $error("table read wrote the wrong register");
    a_refused_form: assert property (rd_req && !form_ok |-> ##1 (fault && !dest_we && !done) ##1 !dest_we)
        else $error("mismatched form not refused");
    a_branch_extra: assert property (br_req |-> ##1 !done ##1 (done && pc == $past(req_target, 2)))
        else $error("branch not two cycles or wrong target");
    a_high_write: assert property (wr_req |-> ##1 (done && table_high_byte_latch == $past(high_wdata)))
        else $error("latch write lost");
    a_latch_cause: assert property ($changed(table_high_byte_latch) |-> dest_we || done)
        else $error("latch changed without a cause");
    a_valid_single: assert property (req_valid |=> !req_valid)
        else $error("request held longer than one cycle");
    a_done_single: assert property (done |=> !done)
        else $error("done held longer than one cycle");
    cover property (rd_req && form_ok);
    cover property (rd_req && !form_ok);
    cover property (br_req);
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench joining the core end to the program memory end
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // ------------------------------------------------
    // stimulus, model and counters
    // ------------------------------------------------
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        user_valid = 1'b0;
    logic [2:0]  user_op = 3'h0;
    logic        user_long = 1'b0;
    logic [1:0]  user_sector = 2'h0;
    logic [7:0]  user_dest = 8'h00;
    logic [12:0] user_target = 13'h0000;
    logic [12:0] ptr = 13'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        tool_data = 1'b1;
    logic        tool_oe = 1'b0;
    logic        tool_clock = 1'b0;
    logic        debug_active = 1'b0;
    logic        prog_active = 1'b0;
    logic        pin_data = 1'b1;
    logic        load_we = 1'b0;
    logic [12:0] load_addr = 13'h0000;
    logic [15:0] load_data = 16'h0000;
    wire logic   user_ready, user_done, ps_data, ps_clock, ds_data, ds_clock, pin_in;
    wire logic [7:0] user_rdata, user_high;
    logic [15:0] model [0:8191];
    integer      seed = 32'h00cb;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          lat;
    int          n_we;
    logic        flt;
    logic [12:0] pc_seen;
    logic [7:0]  dst_seen;
    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;
    pmtr_if pmtr_if_inst ();
    pmtr_device pmtr_device_inst (.clk_sys(clk_sys), .reset_n(reset_n), .bus(pmtr_if_inst),
        .debug_active(debug_active), .prog_active(prog_active), .load_we(load_we), .load_addr(load_addr),
        .load_data(load_data), .pin_func_data(pin_data), .prog_serial_data_in(ps_data), .prog_serial_clock(ps_clock),
        .debug_serial_data_in(ds_data), .debug_serial_clock(ds_clock), .pin_func_in(pin_in));
    pmtr_core pmtr_core_inst (.clk_sys(clk_sys), .reset_n(reset_n), .bus(pmtr_if_inst), .user_valid(user_valid),
        .user_op(user_op), .user_long(user_long), .user_sector(user_sector), .user_dest(user_dest),
        .user_target(user_target), .user_ptr_low(ptr[7:0]), .user_ptr_high(ptr[12:8]), .user_high_wdata(wdata),
        .user_tool_data(tool_data), .user_tool_oe(tool_oe), .user_tool_clock(tool_clock),
        .user_ready(user_ready), .user_done(user_done), .user_rdata(user_rdata), .user_high(user_high));
    pmtr_checker pmtr_checker_inst (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(pmtr_if_inst.req_valid),
        .req_op(pmtr_if_inst.req_op), .req_long(pmtr_if_inst.req_long), .req_sector(pmtr_if_inst.req_sector),
        .req_dest(pmtr_if_inst.req_dest), .req_target(pmtr_if_inst.req_target),
        .high_wdata(pmtr_if_inst.high_wdata), .busy(pmtr_if_inst.busy), .done(pmtr_if_inst.done),
        .fault(pmtr_if_inst.fault), .pc(pmtr_if_inst.pc), .dest_we(pmtr_if_inst.dest_we),
        .dest_addr(pmtr_if_inst.dest_addr), .table_high_byte_latch(pmtr_if_inst.table_high_byte_latch));
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic give_up();
        num_errors++;
        $display("[FAIL] %0t wait ran out got %h expected %h", $time, 1'b0, 1'b1);
        summarize();
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // leaves the strobe high so back-to-back loads never toggle it twice
    task automatic load(input logic [12:0] a, input logic [15:0] d);
        load_we = 1'b1;
        load_addr = a;
        load_data = d;
        model[a] = d;
        @(negedge clk_sys);
    endtask
    // one request, then record latency from the request pulse to done or fault
    task automatic issue(input logic [2:0] op, input logic lng, input logic [1:0] sec, input logic [12:0] tgt);
        int k;
        int r;
        r = -1;
        for (k = 0; k < 20 && user_ready !== 1'b1; k++) @(negedge clk_sys);
        if (k == 20) give_up();
        user_valid = 1'b1;
        user_op = op;
        user_long = lng;
        user_sector = sec;
        user_dest = 8'($random(seed));
        user_target = tgt;
        @(negedge clk_sys);
        user_valid = 1'b0;
        n_we = 0;
        for (k = 0; k < 20; k++) begin
            if (pmtr_if_inst.req_valid === 1'b1 && r < 0) r = k;
            if (pmtr_if_inst.dest_we === 1'b1) n_we++;
            if (pmtr_if_inst.done === 1'b1 || pmtr_if_inst.fault === 1'b1) break;
            @(negedge clk_sys);
        end
        if (k == 20) give_up();
        lat = k - r;
        flt = pmtr_if_inst.fault;
        pc_seen = pmtr_if_inst.pc;
        dst_seen = pmtr_if_inst.dest_addr;
        @(negedge clk_sys);
        check({15'h0000, user_done}, 16'h0001);
    endtask
    // bounded watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_sys);
        give_up();
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        int i;
        logic [12:0] a;
        logic [15:0] w;
        repeat (3) @(negedge clk_sys);
        check({3'h0, pmtr_if_inst.pc}, 16'h0000);
        reset_n = 1'b1;
        load(13'h0000, 16'($random(seed)));
        load_we = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        reset_n = 1'b1;
        for (i = 0; i < 10 && pmtr_if_inst.instr_valid !== 1'b1; i++) @(negedge clk_sys);
        if (i == 10) give_up();
        check(pmtr_if_inst.instr, model[0]);
        // the alias differs only in the top pointer bit, so a dropped high pointer shows
        for (i = 0; i < 12; i++) begin
            a = (i == 0) ? 13'h1fff : (i == 1) ? 13'h1f06 : 13'($random(seed));
            w = 16'($random(seed));
            load(a ^ 13'h1000, ~w);
            load(a, w);
            load_we = 1'b0;
            ptr = a;
            issue(pmtr_pkg::PMTR_OP_TABRD, i[0], i[0] ? 2'(1 + i % 3) : 2'h0, 13'h0000);
            check(16'(lat), 16'h0002);
            check(16'(n_we), 16'h0001);
            check({8'h00, dst_seen}, {8'h00, user_dest});
            check({8'h00, user_rdata}, {8'h00, model[a][7:0]});
            check({8'h00, user_high}, {8'h00, model[a][15:8]});
        end
        for (i = 0; i < 2; i++) begin
            issue(pmtr_pkg::PMTR_OP_TABRD, !i[0], i[0] ? 2'h2 : 2'h0, 13'h0000);
            check({15'h0000, flt}, 16'h0001);
            check({8'h00, user_rdata}, {8'h00, model[a][7:0]});
        end
        for (i = 0; i < 3; i++) begin
            a = 13'($random(seed));
            issue(pmtr_pkg::PMTR_OP_BRANCH, 1'b0, 2'h0, a);
            check(16'(lat), 16'h0002);
            check({3'h0, pc_seen}, {3'h0, a});
        end
        for (i = 0; i < 2; i++) begin
            wdata = i[0] ? 8'hff : 8'($random(seed));
            issue(pmtr_pkg::PMTR_OP_WRHIGH, 1'b0, 2'h0, 13'h0000);
            check(16'(lat), 16'h0001);
            check({8'h00, user_high}, {8'h00, wdata});
        end
        tool_oe = 1'b1;
        tool_data = 1'b0;
        tool_clock = 1'b1;
        prog_active = 1'b1;
        repeat (4) @(negedge clk_sys);
        check({15'h0000, ps_data}, 16'h0000);
        check({15'h0000, ps_clock}, 16'h0001);
        check({15'h0000, pmtr_if_inst.data_level}, 16'h0000);
        check({15'h0000, pmtr_if_inst.dev_data_oe}, 16'h0000);
        prog_active = 1'b0;
        debug_active = 1'b1;
        repeat (4) @(negedge clk_sys);
        check({15'h0000, ds_data}, 16'h0000);
        check({15'h0000, ds_clock}, 16'h0001);
        check({15'h0000, pin_in}, 16'h0000);
        tool_data = 1'b1;
        repeat (4) @(negedge clk_sys);
        check({15'h0000, ds_data}, 16'h0001);
        check({15'h0000, pin_in}, 16'h0000);
        debug_active = 1'b0;
        tool_oe = 1'b0;
        tool_clock = 1'b0;
        pin_data = 1'b0;
        repeat (4) @(negedge clk_sys);
        check({15'h0000, ds_clock}, 16'h0000);
        check({15'h0000, pin_in}, 16'h0000);
        check({15'h0000, pmtr_if_inst.dev_data_oe}, 16'h0001);
        summarize();
    end
endmodule
`default_nettype wire
